/* design/rli_locked_indirect.sv */
// Lock and key gate plus address and control logic for indirect access to clock registers.
// Assumes the internal registers sit on the same clock and answer within one access.
`timescale 1ns/100ps

// Functional notes
// - Lock register read returns state code 0 locked,1 first key,2 unlocked,3 disabled.
// - Writing first then second key while locked unlocks the interface.
// - After first key, any lock register write other than second key disables the interface.
// - Any lock register write while unlocked returns to locked.
// - Disabled state ignores all lock writes until system reset.
// - Address bit 7 shows busy; writing 1 starts an indirect read.
// - Address bit 6 enables automatic follow-on reads.
// - Address bit 5 reads zero and ignores writes.
// - Address bit 4 selects the shortened access strobe.
// - Low four address bits select the internal target register.
// - Address increments after each access to snapshot or wake match bytes.
// - Data register write while unlocked starts an indirect write.
// - Access lasts seven cycles, six with short strobe; short enabled after reset.
// - Indirect access attempt while locked disables the interface until reset.
// - With follow-on reads enabled, each data read while unlocked and not busy starts the next read.
module rli_locked_indirect #(
  parameter int ACC_NORMAL = rli_pkg::ACC_NORMAL,
  parameter int ACC_SHORT = rli_pkg::ACC_SHORT
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Special function register bus
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Internal clock register side
  output logic [3:0] rtcAddr,
  output logic rtcStrobe,
  output logic rtcWrite,
  output logic [7:0] rtcWrData,
  input wire logic [7:0] rtcRdData
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  rli_pkg::rli_lock_t lockState_ff;
  rli_pkg::rli_lock_t nxt_lockState;
  logic busy_ff;
  logic accWrite_ff;
  logic accShort_ff;
  logic [2:0] accCnt_ff;
  logic followOn_ff;
  logic shortSel_ff;
  logic [3:0] addr_ff;
  logic [7:0] data_ff;
  logic [7:0] sfrRdData_ff;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire keyWr = sfrWrEn && (sfrAddr == rli_pkg::KEY_OFFSET);
  wire adrWr = sfrWrEn && (sfrAddr == rli_pkg::ADR_OFFSET);
  wire datWr = sfrWrEn && (sfrAddr == rli_pkg::DAT_OFFSET);
  wire keyRd = sfrRdEn && (sfrAddr == rli_pkg::KEY_OFFSET);
  wire adrRd = sfrRdEn && (sfrAddr == rli_pkg::ADR_OFFSET);
  wire datRd = sfrRdEn && (sfrAddr == rli_pkg::DAT_OFFSET);
  wire unlocked = lockState_ff == rli_pkg::LS_UNLOCKED;
  wire rdStartReq = adrWr && sfrWrData[rli_pkg::BUSY_BIT];
  wire autoRdReq = datRd && followOn_ff;
  // Software must poll busy; requests during an access are dropped, not queued.
  wire startRd = unlocked && !busy_ff && (rdStartReq || autoRdReq);
  wire startWr = unlocked && !busy_ff && datWr;
  wire startAcc = startRd || startWr;
  wire lockedAttempt = !unlocked && (rdStartReq || datWr);
  wire cfgWr = unlocked && !busy_ff && adrWr;
  wire accDone = busy_ff && (accCnt_ff == 3'd0);
  wire inSnap = (addr_ff >= rli_pkg::SNAP_FIRST) && (addr_ff <= rli_pkg::SNAP_LAST);
  wire inWake = (addr_ff >= rli_pkg::WAKE_FIRST) && (addr_ff <= rli_pkg::WAKE_LAST);
  wire [2:0] accLoad = shortSel_ff ? 3'(ACC_SHORT - 1) : 3'(ACC_NORMAL - 1);

  wire [7:0] stateCode =
    (lockState_ff == rli_pkg::LS_FIRST) ? rli_pkg::CODE_FIRST :
    (lockState_ff == rli_pkg::LS_UNLOCKED) ? rli_pkg::CODE_UNLOCKED :
    (lockState_ff == rli_pkg::LS_DISABLED) ? rli_pkg::CODE_DISABLED :
    rli_pkg::CODE_LOCKED;
  wire [7:0] adrView = {busy_ff, followOn_ff, 1'b0, shortSel_ff, addr_ff};
  wire [7:0] rdMux =
    keyRd ? stateCode :
    adrRd ? (unlocked ? adrView : 8'h00) :
    datRd ? (unlocked ? data_ff : 8'h00) :
    8'h00;

  // ----------------------------------------
  // Lock and key machine
  // ----------------------------------------
  always_comb begin
    nxt_lockState = lockState_ff;
    case (lockState_ff)
      rli_pkg::LS_LOCKED: begin
        if (lockedAttempt) begin
          nxt_lockState = rli_pkg::LS_DISABLED;
        end else if (keyWr) begin
          nxt_lockState = (sfrWrData == rli_pkg::KEY_FIRST) ? rli_pkg::LS_FIRST :
                          rli_pkg::LS_DISABLED;
        end
      end
      rli_pkg::LS_FIRST: begin
        if (lockedAttempt) begin
          nxt_lockState = rli_pkg::LS_DISABLED;
        end else if (keyWr) begin
          nxt_lockState = (sfrWrData == rli_pkg::KEY_SECOND) ? rli_pkg::LS_UNLOCKED :
                          rli_pkg::LS_DISABLED;
        end
      end
      rli_pkg::LS_UNLOCKED: begin
        if (keyWr) begin
          nxt_lockState = rli_pkg::LS_LOCKED;
        end
      end
      rli_pkg::LS_DISABLED: begin
        nxt_lockState = rli_pkg::LS_DISABLED;
      end
      default: begin
        nxt_lockState = rli_pkg::LS_DISABLED;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lockState_ff <= rli_pkg::LS_LOCKED;
    end else begin
      lockState_ff <= nxt_lockState;
    end
  end

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  // access length
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy_ff <= 1'b0;
      accCnt_ff <= 3'd0;
      accWrite_ff <= 1'b0;
      accShort_ff <= 1'b0;
    end else if (startAcc) begin
      busy_ff <= 1'b1;
      accCnt_ff <= accLoad;
      accWrite_ff <= startWr;
      accShort_ff <= shortSel_ff;
    end else if (accDone) begin
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      accCnt_ff <= accCnt_ff - 3'd1;
    end
  end

  // ----------------------------------------
  // Address and control register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      followOn_ff <= rli_pkg::RST_FOLLOW;
      shortSel_ff <= rli_pkg::RST_SHORT;
      addr_ff <= rli_pkg::RST_ADDR;
    end else if (cfgWr) begin
      followOn_ff <= sfrWrData[rli_pkg::FOLLOW_BIT];
      shortSel_ff <= sfrWrData[rli_pkg::SHORT_BIT];
      addr_ff <= sfrWrData[3:0];
    end else if (accDone && (inSnap || inWake)) begin
      addr_ff <= addr_ff + 4'd1;
    end
  end

  // ----------------------------------------
  // Data register and read port
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      data_ff <= rli_pkg::RST_DATA;
      sfrRdData_ff <= 8'h00;
    end else begin
      sfrRdData_ff <= rdMux;
      if (startWr) begin
        data_ff <= sfrWrData;
      end else if (accDone && !accWrite_ff) begin
        data_ff <= rtcRdData;
      end
    end
  end

  assign sfrRdData = sfrRdData_ff;
  assign rtcAddr = addr_ff;
  assign rtcStrobe = busy_ff;
  assign rtcWrite = accWrite_ff;
  assign rtcWrData = data_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence shortRun;
    busy_ff [*6] ##1 !busy_ff;
  endsequence
  sequence longRun;
    busy_ff [*7] ##1 !busy_ff;
  endsequence

  lockStatus_read_a: assert property (keyRd |=> sfrRdData_ff == $past(stateCode))
    else $error("Lock status readback wrong.");
  unlockSeq_a: assert property (lockState_ff == rli_pkg::LS_FIRST && keyWr
    && sfrWrData == rli_pkg::KEY_SECOND |=> unlocked)
    else $error("Second key did not unlock.");
  badKey_a: assert property (lockState_ff == rli_pkg::LS_FIRST && keyWr
    && sfrWrData != rli_pkg::KEY_SECOND |=> lockState_ff == rli_pkg::LS_DISABLED)
    else $error("Wrong second key did not disable.");
  relock_a: assert property (unlocked && keyWr |=> lockState_ff == rli_pkg::LS_LOCKED)
    else $error("Write while unlocked did not relock.");
  disabledSticky_a: assert property (lockState_ff == rli_pkg::LS_DISABLED
    |=> lockState_ff == rli_pkg::LS_DISABLED)
    else $error("Disabled state left without reset.");
  bitFive_zero_a: assert property (adrRd |=> !sfrRdData_ff[rli_pkg::UNUSED_BIT])
    else $error("Unused address bit read nonzero.");
  shortAccess_a: assert property ($rose(busy_ff) && accShort_ff |-> shortRun)
    else $error("Short access not six cycles.");
  longAccess_a: assert property ($rose(busy_ff) && !accShort_ff |-> longRun)
    else $error("Normal access not seven cycles.");
  autoInc_a: assert property (accDone && (inSnap || inWake)
    |=> addr_ff == $past(addr_ff) + 4'd1)
    else $error("Address did not increment.");
  dataWrStart_a: assert property (startWr |=> busy_ff && rtcWrite
    && rtcWrData == $past(sfrWrData))
    else $error("Data write did not start access.");
  // An access already in flight when the lock drops may finish; none may start.
  lockedAttempt_a: assert property (lockedAttempt
    |=> lockState_ff == rli_pkg::LS_DISABLED && !$rose(busy_ff))
    else $error("Locked attempt did not disable.");
  followOn_a: assert property (unlocked && !busy_ff && autoRdReq
    |=> busy_ff && !rtcWrite)
    else $error("Follow-on read did not start.");

  // ----------------------------------------
  // Configuration and data path checks
  // ----------------------------------------
  // A read launch is busy with the write direction low.
  sequence rdLaunch;
    busy_ff && !accWrite_ff;
  endsequence

  rdStart_a: assert property (unlocked && !busy_ff && rdStartReq |=> rdLaunch)
    else $error("Busy bit write did not start a read.");
  busyView_a: assert property (adrRd && unlocked
    |=> sfrRdData_ff[rli_pkg::BUSY_BIT] == $past(busy_ff))
    else $error("Busy bit readback wrong.");
  followCfg_a: assert property (cfgWr
    |=> followOn_ff == $past(sfrWrData[rli_pkg::FOLLOW_BIT]))
    else $error("Follow-on enable not stored.");
  shortCfg_a: assert property (cfgWr
    |=> shortSel_ff == $past(sfrWrData[rli_pkg::SHORT_BIT]))
    else $error("Short strobe select not stored.");
  addrCfg_a: assert property (cfgWr |=> rtcAddr == $past(sfrWrData[3:0]))
    else $error("Target address not stored.");
  // Config writes during an access are dropped so an access never sees its target move.
  cfgRefused_a: assert property (adrWr && !cfgWr && !accDone
    |=> $stable(addr_ff))
    else $error("Refused address write took effect.");
  noIncOut_a: assert property (accDone && !(inSnap || inWake)
    |=> $stable(addr_ff))
    else $error("Address moved outside the increment ranges.");
  wrSteady_a: assert property (busy_ff && accWrite_ff && !accDone
    |=> $stable(rtcWrData) && $stable(rtcAddr))
    else $error("Write data or target moved during access.");
  rdCapture_a: assert property (accDone && !accWrite_ff
    |=> data_ff == $past(rtcRdData))
    else $error("Read data not captured at access end.");
  dataView_a: assert property (datRd && unlocked
    |=> sfrRdData_ff == $past(data_ff))
    else $error("Data register readback wrong.");
  readGate_a: assert property ((adrRd || datRd) && !unlocked
    |=> sfrRdData_ff == 8'h00)
    else $error("Gated register read returned data.");
  firstKey_a: assert property (lockState_ff == rli_pkg::LS_LOCKED && keyWr
    && sfrWrData == rli_pkg::KEY_FIRST |=> lockState_ff == rli_pkg::LS_FIRST)
    else $error("First key not accepted.");

endmodule

/* include/rli_pkg.sv */
// Constants, register map and lock state type of the locked indirect access bridge.
// Assumes a byte-wide special function register bus on the system clock.
package rli_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADR_OFFSET = 8'h00_AC;
  localparam logic [7:0] DAT_OFFSET = 8'h00_AD;
  localparam logic [7:0] KEY_OFFSET = 8'h00_AE;

  // ----------------------------------------
  // Address register fields and reset values
  // ----------------------------------------
  localparam int BUSY_BIT = 7;
  localparam int FOLLOW_BIT = 6;
  localparam int UNUSED_BIT = 5;
  localparam int SHORT_BIT = 4;
  localparam logic RST_SHORT = 1'b1;
  localparam logic RST_FOLLOW = 1'b0;
  localparam logic [3:0] RST_ADDR = 4'h0;
  localparam logic [7:0] RST_DATA = 8'h00;

  // ----------------------------------------
  // Key codes and status codes
  // ----------------------------------------
  localparam logic [7:0] KEY_FIRST = 8'h00_A5;
  localparam logic [7:0] KEY_SECOND = 8'h00_F1;
  localparam logic [7:0] CODE_LOCKED = 8'h00_00;
  localparam logic [7:0] CODE_FIRST = 8'h00_01;
  localparam logic [7:0] CODE_UNLOCKED = 8'h00_02;
  localparam logic [7:0] CODE_DISABLED = 8'h00_03;

  // ----------------------------------------
  // Internal address ranges that auto-increment
  // ----------------------------------------
  localparam logic [3:0] SNAP_FIRST = 4'h0;
  localparam logic [3:0] SNAP_LAST = 4'h3;
  localparam logic [3:0] WAKE_FIRST = 4'h8;
  localparam logic [3:0] WAKE_LAST = 4'hB;

  // ----------------------------------------
  // Access lengths in system clock cycles
  // ----------------------------------------
  localparam int ACC_NORMAL = 7;
  localparam int ACC_SHORT = 6;

  typedef enum logic [1:0] {
    LS_LOCKED = 2'b00,
    LS_FIRST = 2'b01,
    LS_UNLOCKED = 2'b11,
    LS_DISABLED = 2'b10
  } rli_lock_t;

endpackage

/* tb/rli_rtc_model.sv */
// Behavioural model of the internal clock register bank behind the bridge.
// Assumes one system clock; an access lasts while the strobe level is high.
`timescale 1ns/100ps
module rli_rtc_model (
  // Clock
  input wire logic core_clk,
  // Access side
  input wire logic [3:0] rtcAddr,
  input wire logic rtcStrobe,
  input wire logic rtcWrite,
  input wire logic [7:0] rtcWrData,
  output logic [7:0] rtcRdData
);
  // Declaration values keep the bank single-driven by the clocked process below.
  logic [7:0] regFile_ff [16] = '{default: 8'h00};

  // Writes land in every strobe cycle, so the last cycle decides.
  always_ff @(posedge core_clk) begin
    if (rtcStrobe && rtcWrite) begin
      regFile_ff[rtcAddr] <= rtcWrData;
    end
  end

  // Outside a read the bank shows inverted data, so stale values never match.
  assign rtcRdData = (rtcStrobe && !rtcWrite) ? regFile_ff[rtcAddr] : ~regFile_ff[rtcAddr];
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the locked indirect access bridge.
// Assumes the register bank model answers on the same clock.
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  localparam logic [7:0] ADR = rli_pkg::ADR_OFFSET;
  localparam logic [7:0] DAT = rli_pkg::DAT_OFFSET;
  localparam logic [7:0] KEY = rli_pkg::KEY_OFFSET;
  logic core_clk, sys_rst, sfrWrEn, sfrRdEn, rtcStrobe, rtcWrite;
  logic [7:0] sfrAddr, sfrWrData, sfrRdData, rtcWrData, rtcRdData, rdVal;
  logic [3:0] rtcAddr;
  logic [7:0] expMem [16];
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;

  rli_locked_indirect u_rli_locked_indirect (.core_clk(core_clk), .sys_rst(sys_rst),
    .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn), .sfrWrData(sfrWrData),
    .sfrRdData(sfrRdData), .rtcAddr(rtcAddr), .rtcStrobe(rtcStrobe),
    .rtcWrite(rtcWrite), .rtcWrData(rtcWrData), .rtcRdData(rtcRdData));
  rli_rtc_model u_rli_rtc_model (.core_clk(core_clk), .rtcAddr(rtcAddr),
    .rtcStrobe(rtcStrobe), .rtcWrite(rtcWrite), .rtcWrData(rtcWrData),
    .rtcRdData(rtcRdData));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // The run needs well under a thousand cycles.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Address register view with busy idle; bit five always reads zero.
  function automatic logic [7:0] adrExp(input logic fo, input logic sh, input logic [3:0] a);
    return {1'b0, fo, 1'b0, sh, a};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrEn = 1'b1;
    @(negedge core_clk);
    sfrWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(negedge core_clk);
    sfrRdEn = 1'b0;
    rdVal = sfrRdData;
  endtask

  // Counts strobe cycles of the access just launched.
  task automatic waitBusy(input int expLen);
    n = 0;
    while (rtcStrobe === 1'b1 && n < 20) begin
      n++;
      @(negedge core_clk);
    end
    `CHK(n, expLen)
  endtask

  task automatic pulseReset();
    @(negedge core_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
  endtask

  initial begin
    void'($urandom(32'h9c8a_a4e0));
    sys_rst = 1'b1;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b0;
    sfrAddr = 8'h00;
    sfrWrData = 8'h00;
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_LOCKED)
    rd(ADR); `CHK(rdVal, 8'h00)
    wr(KEY, rli_pkg::KEY_FIRST);
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_FIRST)
    wr(KEY, rli_pkg::KEY_SECOND);
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_UNLOCKED)
    rd(ADR); `CHK(rdVal, adrExp(rli_pkg::RST_FOLLOW, rli_pkg::RST_SHORT, rli_pkg::RST_ADDR))
    for (int b = 0; b < 16; b += 8) begin
      wr(ADR, 8'h30 | 8'(b));
      rd(ADR); `CHK(rdVal, 8'h10 | 8'(b))
      for (int i = 0; i < 4; i++) begin
        expMem[b + i] = 8'($urandom);
        wr(DAT, expMem[b + i]);
        waitBusy(rli_pkg::ACC_SHORT);
      end
      rd(ADR); `CHK(rdVal, adrExp(1'b0, 1'b1, 4'(b + 4)))
      wr(ADR, 8'hD0 | 8'(b));
      waitBusy(rli_pkg::ACC_SHORT);
      for (int i = 0; i < 4; i++) begin
        rd(DAT); `CHK(rdVal, expMem[b + i])
        waitBusy(rli_pkg::ACC_SHORT);
      end
    end
    // Address outside both ranges, normal strobe, no follow-on reads.
    wr(ADR, 8'h05);
    rd(ADR); `CHK(rdVal, 8'h05)
    expMem[5] = 8'($urandom);
    wr(DAT, expMem[5]);
    waitBusy(rli_pkg::ACC_NORMAL);
    rd(ADR); `CHK(rdVal, 8'h05)
    wr(ADR, 8'h85);
    waitBusy(rli_pkg::ACC_NORMAL);
    rd(DAT); `CHK(rdVal, expMem[5])
    `CHK(rtcStrobe, 1'b0)
    wr(KEY, 8'($urandom));
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_LOCKED)
    wr(ADR, 8'h0A);
    rd(ADR); `CHK(rdVal, 8'h00)
    wr(DAT, 8'h00);
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_DISABLED)
    wr(KEY, rli_pkg::KEY_FIRST);
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_DISABLED)
    pulseReset();
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_LOCKED)
    wr(KEY, rli_pkg::KEY_FIRST);
    wr(KEY, rli_pkg::KEY_SECOND ^ 8'(1 + $urandom % 255));
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_DISABLED)
    pulseReset();
    wr(KEY, rli_pkg::KEY_FIRST ^ 8'(1 + $urandom % 255));
    rd(KEY); `CHK(rdVal, rli_pkg::CODE_DISABLED)
    finish_test();
  end
endmodule
